// *** olipt_consts.vh ***
// Constants for the output line invert and pulse timer block.
// Included by the tick generator and top design files of the block; definitions only.
`ifndef OLIPT_CONSTS_VH
`define OLIPT_CONSTS_VH

// ==========================================================
// Register word offsets (byte address = index * 4)
`define OLIPT_REG_CTRL        4'h0
`define OLIPT_REG_USER        4'h1
`define OLIPT_REG_DLY_RAW     4'h2
`define OLIPT_REG_DLY_BASE    4'h3
`define OLIPT_REG_DLY_ABS     4'h4
`define OLIPT_REG_DUR_RAW     4'h5
`define OLIPT_REG_DUR_BASE    4'h6
`define OLIPT_REG_DUR_ABS     4'h7
`define OLIPT_REG_STATUS      4'h8

// ==========================================================
// Control register fields
`define OLIPT_CTRL_INV_BIT    0
`define OLIPT_CTRL_SRC_BIT    1
`define OLIPT_CTRL_TSRC_BIT   2

// ==========================================================
// Reset values
`define OLIPT_RST_RAW         12'h000
`define OLIPT_RST_BASE        16'h0001
`define OLIPT_BASE_MIN        16'h0001

// ==========================================================
// Timing: one microsecond tick at the core clock
`define OLIPT_TICK_NS         1000
`define OLIPT_CLK_NS          5
`define OLIPT_TICK_CYC        (`OLIPT_TICK_NS / `OLIPT_CLK_NS)

`endif

// *** olipt_us_tick.v ***
// Microsecond tick generator.
// Assumes a free-running core clock at the rate in the constants header.
`timescale 1ns/1ps
`include "olipt_consts.vh"

module olipt_us_tick #(
  parameter CYC = `OLIPT_TICK_CYC
) (
  // Clock and reset
  input  wire       i_clk,
  input  wire       i_rst_n,
  // Tick
  output reg        o_tick
);

  reg  [15:0] cnt_r;

  always @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      cnt_r  <= 16'h0000;
      o_tick <= 1'b0;
    end
    else if (cnt_r == CYC[15:0] - 16'h0001)
    begin
      cnt_r  <= 16'h0000;
      o_tick <= 1'b1;
    end
    else
    begin
      cnt_r  <= cnt_r + 16'h0001;
      o_tick <= 1'b0;
    end
  end

endmodule // olipt_us_tick

// *** olipt_abs_conv.v ***
// Converts an absolute time in microseconds to a raw count for a time base.
// Sequential divider by repeated subtraction; result rounds to nearest.
// Assumes base is at least one; a start while busy is ignored.
`timescale 1ns/1ps

module olipt_abs_conv (
  // Clock and reset
  input  wire        i_clk,
  input  wire        i_rst_n,
  // Request
  input  wire        i_start,
  input  wire [31:0] i_abs,
  input  wire [15:0] i_base,
  // Answer
  output wire        o_busy,
  output reg         o_done,
  output reg  [11:0] o_raw
);

  reg         busy_r;
  reg  [31:0] rem_r;
  reg  [31:0] quo_r;
  reg  [15:0] base_r;
  wire [31:0] base_w = {16'h0000, base_r};
  wire [31:0] half_w = {17'h00000, base_r[15:1]};

  assign o_busy = busy_r;

  always @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      busy_r <= 1'b0;
      rem_r  <= 32'h00000000;
      quo_r  <= 32'h00000000;
      base_r <= 16'h0001;
      o_done <= 1'b0;
      o_raw  <= 12'h000;
    end
    else
    begin
      o_done <= 1'b0;
      if (!busy_r)
      begin
        if (i_start)
        begin
          busy_r <= 1'b1;
          rem_r  <= i_abs;
          quo_r  <= 32'h00000000;
          base_r <= i_base;
        end
      end
      else if (rem_r >= base_w)
      begin
        rem_r <= rem_r - base_w;
        quo_r <= quo_r + 32'h00000001;
      end
      else
      begin
        // Round to the nearest multiple, then clamp to the raw range
        busy_r <= 1'b0;
        o_done <= 1'b1;
        if ((rem_r > half_w) || ((rem_r == half_w) && base_r[0] == 1'b0 && rem_r != 0))
        begin
          o_raw <= (quo_r + 32'h1 > 32'hfff) ? 12'hfff : quo_r[11:0] + 12'h001;
        end
        else
        begin
          o_raw <= (quo_r > 32'hfff) ? 12'hfff : quo_r[11:0];
        end
      end
    end
  end

endmodule // olipt_abs_conv

// *** olipt_top.v ***
// Output line invert and delayed-pulse timer with an Avalon-MM register slave.
// Assumes exposure start arrives synchronous to i_clk; software configures
// line direction before use on lines that can also be inputs.
//
// Decided for this implementation: the placing of the registers and the Avalon-MM slave port.
`timescale 1ns/1ps
`include "olipt_consts.vh"

// What this block does
// - No inversion: control one drives transistor on
// - Inversion: control zero drives transistor on
// - User level enters ahead of the inverter
// - Software-written inversion enable bit for line
// - Timer-active source drives line from timer
// - Trigger starts delay, timer signal low
// - Delay end: signal high, duration starts
// - Duration end: signal returns low
// - Only exposure start triggers the timer
// - Delay equals raw count times base
// - Raw delay accepts zero through 4095
// - Delay base defaults one, whole-microsecond steps
// - Absolute delay setting in microseconds
// - Unreachable absolute rounds to nearest raw
// - Raw write updates absolute readback
// - Duration is raw times base, 0..4095
module olipt_top #(
  parameter RAW_W  = 12,
  parameter BASE_W = 16
) (
  // Clock and reset
  input  wire        i_clk,
  input  wire        i_rst_n,
  // Avalon-MM slave
  input  wire [3:0]  i_avs_address,
  input  wire        i_avs_read,
  input  wire        i_avs_write,
  input  wire [31:0] i_avs_writedata,
  input  wire [3:0]  i_avs_byteenable,
  output reg  [31:0] o_avs_readdata,
  output wire        o_avs_waitrequest,
  // Camera events
  input  wire        i_exposure_start,
  // Output line
  output reg         o_output_transistor,
  output wire        o_timer_active
);

  // ==========================================================
  // Registers
  localparam ST_IDLE = 2'd0;
  localparam ST_DLY  = 2'd1;
  localparam ST_DUR  = 2'd2;

  // Line settings: inversion, source select and the user level.
  // The user level is stored before the inverter, so reading it back
  // gives what software wrote, not what the pin shows.
  reg              inv_r;
  reg              src_timer_r;
  reg              user_r;
  // Timer settings: raw counts and time bases, in microseconds.
  // A base of zero is refused and stored as one.
  reg [RAW_W-1:0]  dly_raw_r;
  reg [BASE_W-1:0] dly_base_r;
  reg [RAW_W-1:0]  dur_raw_r;
  reg [BASE_W-1:0] dur_base_r;
  // Bus state: marks the second cycle of a read.
  reg              rd_done_r;
  // Timer state and its two counters.
  // raw_cnt_r counts whole base units, base_cnt_r counts ticks in a unit.
  reg [1:0]        st_r;
  reg [RAW_W-1:0]  raw_cnt_r;
  reg [BASE_W-1:0] base_cnt_r;
  // Converter bookkeeping: which raw register the result goes to, and
  // whether a conversion is owed to the bus master still waiting.
  reg              conv_dur_r;
  reg              conv_wait_r;

  wire        tick;
  wire        conv_busy;
  wire        conv_done;
  wire [11:0] conv_raw;
  wire        wr_hit;

  // Products give the absolute readbacks; always consistent with raw and base
  wire [31:0] dly_abs = {{(32-RAW_W){1'b0}}, dly_raw_r} * {{(32-BASE_W){1'b0}}, dly_base_r};
  wire [31:0] dur_abs = {{(32-RAW_W){1'b0}}, dur_raw_r} * {{(32-BASE_W){1'b0}}, dur_base_r};

  // ==========================================================
  // Microsecond tick and absolute-to-raw converter
  olipt_us_tick u_tick (
    .i_clk   (i_clk),
    .i_rst_n (i_rst_n),
    .o_tick  (tick)
  );

  olipt_abs_conv u_conv (
    .i_clk   (i_clk),
    .i_rst_n (i_rst_n),
    .i_start (wr_hit && (i_avs_address == `OLIPT_REG_DLY_ABS ||
                         i_avs_address == `OLIPT_REG_DUR_ABS)),
    .i_abs   (i_avs_writedata),
    .i_base  ((i_avs_address == `OLIPT_REG_DUR_ABS) ? dur_base_r : dly_base_r),
    .o_busy  (conv_busy),
    .o_done  (conv_done),
    .o_raw   (conv_raw)
  );

  // ==========================================================
  // Bus handshake
  // Reads take one wait cycle; an absolute write waits for the divider,
  // so software sees the rounded raw value once the write completes.
  wire is_abs_addr = (i_avs_address == `OLIPT_REG_DLY_ABS) ||
                     (i_avs_address == `OLIPT_REG_DUR_ABS);
  assign wr_hit = i_avs_write && !conv_busy && !conv_wait_r && !conv_done;
  assign o_avs_waitrequest = (i_avs_read && !rd_done_r) ||
                             (i_avs_write && is_abs_addr && !conv_done) ||
                             (i_avs_write && !is_abs_addr && conv_busy);

  always @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      rd_done_r      <= 1'b0;
      o_avs_readdata <= 32'h00000000;
    end
    else
    begin
      rd_done_r <= i_avs_read && !rd_done_r;
      if (i_avs_read && !rd_done_r)
      begin
        case (i_avs_address)
          `OLIPT_REG_CTRL:
            o_avs_readdata <= {29'h0, 1'b1, src_timer_r, inv_r};
          `OLIPT_REG_USER:     o_avs_readdata <= {31'h0, user_r};
          `OLIPT_REG_DLY_RAW:  o_avs_readdata <= {{(32-RAW_W){1'b0}}, dly_raw_r};
          `OLIPT_REG_DLY_BASE: o_avs_readdata <= {{(32-BASE_W){1'b0}}, dly_base_r};
          `OLIPT_REG_DLY_ABS:  o_avs_readdata <= dly_abs;
          `OLIPT_REG_DUR_RAW:  o_avs_readdata <= {{(32-RAW_W){1'b0}}, dur_raw_r};
          `OLIPT_REG_DUR_BASE: o_avs_readdata <= {{(32-BASE_W){1'b0}}, dur_base_r};
          `OLIPT_REG_DUR_ABS:  o_avs_readdata <= dur_abs;
          `OLIPT_REG_STATUS:   o_avs_readdata <= {29'h0, o_timer_active, st_r};
          default:             o_avs_readdata <= 32'h00000000;
        endcase
      end
    end
  end

  // ==========================================================
  // Register writes
  // Byte enables honoured on the low two lanes; absolute writes ignore them and take all four lanes.
  always @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      inv_r       <= 1'b0;
      src_timer_r <= 1'b0;
      user_r      <= 1'b0;
      dly_raw_r   <= `OLIPT_RST_RAW;
      dly_base_r  <= `OLIPT_RST_BASE;
      dur_raw_r   <= `OLIPT_RST_RAW;
      dur_base_r  <= `OLIPT_RST_BASE;
      conv_dur_r  <= 1'b0;
      conv_wait_r <= 1'b0;
    end
    else
    begin
      if (conv_done)
      begin
        conv_wait_r <= 1'b0;
        if (conv_dur_r)
          dur_raw_r <= conv_raw[RAW_W-1:0];
        else
          dly_raw_r <= conv_raw[RAW_W-1:0];
      end
      else if (wr_hit)
      begin
        case (i_avs_address)
          `OLIPT_REG_CTRL:
            if (i_avs_byteenable[0])
            begin
              inv_r       <= i_avs_writedata[`OLIPT_CTRL_INV_BIT];
              src_timer_r <= i_avs_writedata[`OLIPT_CTRL_SRC_BIT];
            end
          `OLIPT_REG_USER:
            if (i_avs_byteenable[0])
              user_r <= i_avs_writedata[0];
          `OLIPT_REG_DLY_RAW:
            if (&i_avs_byteenable[1:0])
              dly_raw_r <= i_avs_writedata[RAW_W-1:0];
          `OLIPT_REG_DLY_BASE:
            if (&i_avs_byteenable[1:0])
              dly_base_r <= (i_avs_writedata[BASE_W-1:0] < `OLIPT_BASE_MIN) ?
                            `OLIPT_BASE_MIN : i_avs_writedata[BASE_W-1:0];
          `OLIPT_REG_DUR_RAW:
            if (&i_avs_byteenable[1:0])
              dur_raw_r <= i_avs_writedata[RAW_W-1:0];
          `OLIPT_REG_DUR_BASE:
            if (&i_avs_byteenable[1:0])
              dur_base_r <= (i_avs_writedata[BASE_W-1:0] < `OLIPT_BASE_MIN) ?
                            `OLIPT_BASE_MIN : i_avs_writedata[BASE_W-1:0];
          `OLIPT_REG_DLY_ABS:
          begin
            conv_dur_r  <= 1'b0;
            conv_wait_r <= 1'b1;
          end
          `OLIPT_REG_DUR_ABS:
          begin
            conv_dur_r  <= 1'b1;
            conv_wait_r <= 1'b1;
          end
          default:
            conv_wait_r <= conv_wait_r;
        endcase
      end
    end
  end

  // ==========================================================
  // Delayed pulse timer
  // Period counts whole time-base units of microsecond ticks; the first unit
  // can be short by under one microsecond since the tick runs free.
  wire base_end_dly = tick && (base_cnt_r >= dly_base_r - {{(BASE_W-1){1'b0}}, 1'b1});
  wire base_end_dur = tick && (base_cnt_r >= dur_base_r - {{(BASE_W-1){1'b0}}, 1'b1});

  always @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      st_r       <= ST_IDLE;
      raw_cnt_r  <= {RAW_W{1'b0}};
      base_cnt_r <= {BASE_W{1'b0}};
    end
    else
    begin
      case (st_r)
        ST_IDLE:
          // Only an idle timer listens; a start during delay or pulse is lost,
          // which keeps one pulse per exposure and avoids a retrigger glitch.
          if (i_exposure_start)
          begin
            base_cnt_r <= {BASE_W{1'b0}};
            raw_cnt_r  <= {RAW_W{1'b0}};
            if (dly_raw_r == {RAW_W{1'b0}})
              st_r <= (dur_raw_r == {RAW_W{1'b0}}) ? ST_IDLE : ST_DUR;
            else
              st_r <= ST_DLY;
          end
        ST_DLY:
          if (base_end_dly)
          begin
            base_cnt_r <= {BASE_W{1'b0}};
            if (raw_cnt_r + {{(RAW_W-1){1'b0}}, 1'b1} >= dly_raw_r)
            begin
              raw_cnt_r <= {RAW_W{1'b0}};
              st_r <= (dur_raw_r == {RAW_W{1'b0}}) ? ST_IDLE : ST_DUR;
            end
            else
              raw_cnt_r <= raw_cnt_r + {{(RAW_W-1){1'b0}}, 1'b1};
          end
          else if (tick)
            base_cnt_r <= base_cnt_r + {{(BASE_W-1){1'b0}}, 1'b1};
        ST_DUR:
          if (base_end_dur)
          begin
            base_cnt_r <= {BASE_W{1'b0}};
            if (raw_cnt_r + {{(RAW_W-1){1'b0}}, 1'b1} >= dur_raw_r)
            begin
              raw_cnt_r <= {RAW_W{1'b0}};
              st_r      <= ST_IDLE;
            end
            else
              raw_cnt_r <= raw_cnt_r + {{(RAW_W-1){1'b0}}, 1'b1};
          end
          else if (tick)
            base_cnt_r <= base_cnt_r + {{(BASE_W-1){1'b0}}, 1'b1};
        default:
          st_r <= ST_IDLE;
      endcase
      // Triggers in ST_DLY or ST_DUR fall through unused
    end
  end

  // Decoded from the state register alone, so it has no glitch and
  // stays low for the whole delay period.
  assign o_timer_active = (st_r == ST_DUR);

  // ==========================================================
  // Output line: source select, then inverter
  wire line_ctrl = src_timer_r ? o_timer_active : user_r;

  // Registered so the pin never glitches when source and inversion
  // change together; costs one cycle of latency on every change.
  always @(posedge i_clk)
  begin
    if (!i_rst_n)
      o_output_transistor <= 1'b0;
    else
      o_output_transistor <= inv_r ? ~line_ctrl : line_ctrl;
  end

endmodule // olipt_top

// *** olipt_light_model.sv ***
// Light source model on the far side of the output line.
// Assumes the lamp is lit exactly while the output transistor conducts.
`timescale 1ns/1ps
module olipt_light_model (
  // Clock
  input  wire        i_clk,
  // Line from the block
  input  wire        i_output_transistor,
  // Length of the last lit interval in cycles
  output reg  [31:0] o_lit_cycles
);
  reg [31:0] run_r;
  reg        on_r;

  always @(posedge i_clk)
  begin
    on_r  <= i_output_transistor;
    run_r <= i_output_transistor ? run_r + 32'h1 : 32'h0;
    if (on_r && !i_output_transistor)
      o_lit_cycles <= run_r;
  end
endmodule // olipt_light_model

// *** olipt_chk_sva.sv ***
// Checker for the output line block, bound to its top-level ports.
// Assumes a 200-cycle microsecond tick and whole-word register writes.
`timescale 1ns/1ps
`include "olipt_consts.vh"
module olipt_chk_sva #(
  parameter TICK = 200
) (
  input wire        i_clk,
  input wire        i_rst_n,
  input wire [3:0]  i_avs_address,
  input wire        i_avs_read,
  input wire        i_avs_write,
  input wire [31:0] i_avs_writedata,
  input wire [31:0] o_avs_readdata,
  input wire        o_avs_waitrequest,
  input wire        i_exposure_start,
  input wire        o_output_transistor,
  input wire        o_timer_active
);
  // ==========================================================
  // Shadow of settings; abs writes mark timing unknown
  reg         inv_r, sel_r, usr_r, busy_r, act_r, dirty_r;
  reg  [11:0] dr_r, ur_r;
  reg  [15:0] db_r, ub_r;
  reg  [31:0] cnt_r;
  wire [15:0] wb   = (i_avs_writedata[15:0] == 16'h0) ? 16'h1 : i_avs_writedata[15:0];
  wire        go   = i_exposure_start && !busy_r;
  wire        lvl  = sel_r ? o_timer_active : usr_r;
  wire [31:0] dexp = dr_r * db_r * TICK;
  wire [31:0] uexp = ur_r * ub_r * TICK;

  always @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      {inv_r, sel_r, usr_r, busy_r, act_r, dirty_r} <= 6'h0;
      {dr_r, ur_r, cnt_r} <= 56'h0;
      {db_r, ub_r} <= 32'h0001_0001;
    end
    else
    begin
      act_r <= o_timer_active;
      cnt_r <= (go || o_timer_active != act_r) ? 32'h0 : cnt_r + 32'h1;
      if (go)
        busy_r <= 1'b1;
      else if (act_r && !o_timer_active)
        busy_r <= 1'b0;
      if (i_avs_write && !o_avs_waitrequest)
        case (i_avs_address)
          `OLIPT_REG_CTRL:     {sel_r, inv_r} <= i_avs_writedata[1:0];
          `OLIPT_REG_USER:     usr_r <= i_avs_writedata[0];
          `OLIPT_REG_DLY_RAW:  {dirty_r, dr_r} <= {1'b0, i_avs_writedata[11:0]};
          `OLIPT_REG_DLY_BASE: db_r <= wb;
          `OLIPT_REG_DUR_RAW:  ur_r <= i_avs_writedata[11:0];
          `OLIPT_REG_DUR_BASE: ub_r <= wb;
          `OLIPT_REG_DLY_ABS, `OLIPT_REG_DUR_ABS: dirty_r <= 1'b1;
          default: ;
        endcase
    end
  end

  // ==========================================================
  // Properties
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  sequence s_rd_go;
    i_avs_read && o_avs_waitrequest;
  endsequence
  sequence s_rd_end;
    i_avs_read && !o_avs_waitrequest;
  endsequence
  property p_no_inv;
    !$past(inv_r) |-> o_output_transistor == $past(lvl);
  endproperty
  a_no_inv: assert property (p_no_inv)
    else $error("pin differs from source");
  property p_inv;
    $past(inv_r) |-> o_output_transistor != $past(lvl);
  endproperty
  a_inv: assert property (p_inv)
    else $error("pin not inverted");
  property p_timer_src;
    $past(sel_r) |-> o_output_transistor == ($past(o_timer_active) ^ $past(inv_r));
  endproperty
  a_timer_src: assert property (p_timer_src)
    else $error("pin not from timer");
  property p_start_low;
    go && dr_r >= 12'h002 && !dirty_r |=> !o_timer_active [*8];
  endproperty
  a_start_low: assert property (p_start_low)
    else $error("timer high at start");
  property p_dly_len;
    $rose(o_timer_active) && !dirty_r |-> cnt_r <= dexp + 32'h3 && cnt_r + TICK >= dexp;
  endproperty
  a_dly_len: assert property (p_dly_len)
    else $error("delay length wrong");
  property p_dur_len;
    $fell(o_timer_active) && !dirty_r |-> cnt_r <= uexp + 32'h3 && cnt_r + TICK + 32'h3 >= uexp;
  endproperty
  a_dur_len: assert property (p_dur_len)
    else $error("pulse length wrong");
  property p_rd_ans;
    s_rd_go |=> s_rd_end;
  endproperty
  a_rd_ans: assert property (p_rd_ans)
    else $error("read not answered");
  property p_abs_rb;
    i_avs_read && !o_avs_waitrequest && i_avs_address == `OLIPT_REG_DLY_ABS && !dirty_r
      |-> o_avs_readdata == {20'h0, dr_r} * {16'h0, db_r};
  endproperty
  a_abs_rb: assert property (p_abs_rb)
    else $error("absolute readback wrong");
  property p_abs_bound;
    i_avs_write && i_avs_address == `OLIPT_REG_DLY_ABS |-> ##[0:1000] !o_avs_waitrequest;
  endproperty
  a_abs_bound: assert property (p_abs_bound)
    else $error("absolute write hangs");
endmodule // olipt_chk_sva

bind olipt_top olipt_chk_sva olipt_chk_sva_i (
  .i_clk(i_clk), .i_rst_n(i_rst_n), .i_avs_address(i_avs_address),
  .i_avs_read(i_avs_read), .i_avs_write(i_avs_write), .i_avs_writedata(i_avs_writedata),
  .o_avs_readdata(o_avs_readdata), .o_avs_waitrequest(o_avs_waitrequest),
  .i_exposure_start(i_exposure_start), .o_output_transistor(o_output_transistor),
  .o_timer_active(o_timer_active)
);

// *** test_output_line_invert_and_pulse_timer.sv ***
// Self-checking bench for the output line block and its register slave.
// Drives bus and exposure start on rising edges; the light model watches the pin.
`timescale 1ns/1ps
`include "olipt_consts.vh"
module test_output_line_invert_and_pulse_timer;
  reg         clk = 1'b0;
  reg         rst_n = 1'b0;
  reg  [3:0]  adr = 4'h0;
  reg         rd = 1'b0;
  reg         wr = 1'b0;
  reg  [31:0] wd = 32'h0;
  reg         xs = 1'b0;
  reg  [31:0] q;
  wire [31:0] rdata, lit;
  wire        wreq, tr, ta;
  integer     err_count = 0;
  integer     cmp_count = 0;
  integer     i, n;

  always #2.5 clk = ~clk;

  olipt_top olipt_top_i (
    .i_clk(clk), .i_rst_n(rst_n), .i_avs_address(adr), .i_avs_read(rd), .i_avs_write(wr),
    .i_avs_writedata(wd), .i_avs_byteenable(4'hf), .o_avs_readdata(rdata),
    .o_avs_waitrequest(wreq), .i_exposure_start(xs), .o_output_transistor(tr),
    .o_timer_active(ta)
  );
  olipt_light_model olipt_light_model_i (
    .i_clk(clk), .i_output_transistor(tr), .o_lit_cycles(lit)
  );

  // ==========================================================
  // Checks and bus access
  task stop_test;
  begin
    if (err_count == 0 && cmp_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  end
  endtask
  task fail(input [31:0] got, input [31:0] exp);
  begin
    err_count = err_count + 1;
    $display("unexpected at %0t: got %h expected %h", $time, got, exp);
  end
  endtask
  task chk(input [31:0] got, input [31:0] exp);
  begin
    cmp_count = cmp_count + 1;
    if (got !== exp)
      fail(got, exp);
  end
  endtask
  task chk_rng(input [31:0] got, input [31:0] lo, input [31:0] hi);
  begin
    cmp_count = cmp_count + 1;
    if ((got >= lo && got <= hi) !== 1'b1)
      fail(got, hi);
  end
  endtask
  // Idle edge at the end keeps back-to-back requests apart
  task bus(input w, input [3:0] a, input [31:0] d);
    integer k;
  begin
    adr <= a;
    wd <= d;
    wr <= w;
    rd <= !w;
    k = 0;
    @(posedge clk);
    while (wreq !== 1'b0 && k < 5000)
    begin
      @(posedge clk);
      k = k + 1;
    end
    q = rdata;
    wr <= 1'b0;
    rd <= 1'b0;
    @(posedge clk);
    if (k >= 5000)
    begin
      fail(k, 5000);
      stop_test;
    end
  end
  endtask
  task rdc(input [3:0] a, input [31:0] e);
  begin
    bus(1'b0, a, 32'h0);
    chk(q, e);
  end
  endtask
  task wt(input v);
  begin
    n = 0;
    while (ta !== v && n < 20000)
    begin
      @(posedge clk);
      n = n + 1;
    end
    if (n >= 20000)
    begin
      fail(n, 20000);
      stop_test;
    end
  end
  endtask
  task trig;
  begin
    xs <= 1'b1;
    @(posedge clk);
    xs <= 1'b0;
  end
  endtask

  // ==========================================================
  // Scenarios
  initial
  begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    for (i = 0; i < 10; i = i + 1)
      rdc(i[3:0], (i == 0) ? 32'h4 : (i == 3 || i == 6) ? 32'h1 : 32'h0);
    for (i = 0; i < 4; i = i + 1)
    begin
      bus(1'b1, `OLIPT_REG_CTRL, {31'h0, i[1]});
      bus(1'b1, `OLIPT_REG_USER, {31'h0, i[0]});
      repeat (2) @(posedge clk);
      chk({31'h0, tr}, {31'h0, i[1] ^ i[0]});
      rdc(`OLIPT_REG_CTRL, {29'h1, 1'b0, i[1]});
    end
    bus(1'b1, `OLIPT_REG_DLY_BASE, 32'h0);
    rdc(`OLIPT_REG_DLY_BASE, 32'h1);
    bus(1'b1, `OLIPT_REG_DLY_BASE, 32'h3);
    bus(1'b1, `OLIPT_REG_DLY_RAW, 32'hfff);
    rdc(`OLIPT_REG_DLY_ABS, 32'h2ffd);
    bus(1'b1, `OLIPT_REG_DLY_RAW, 32'h1000);
    rdc(`OLIPT_REG_DLY_RAW, 32'h0);
    bus(1'b1, `OLIPT_REG_CTRL, 32'h2);
    bus(1'b1, `OLIPT_REG_DLY_BASE, 32'h1);
    bus(1'b1, `OLIPT_REG_DLY_RAW, 32'h3);
    bus(1'b1, `OLIPT_REG_DUR_BASE, 32'h2);
    bus(1'b1, `OLIPT_REG_DUR_RAW, 32'h3);
    trig;
    wt(1'b1);
    chk_rng(n, 32'h18e, 32'h25c);
    rdc(`OLIPT_REG_STATUS, 32'h6);
    trig;
    wt(1'b0);
    chk_rng(n, 32'h3e6, 32'h4b4);
    repeat (3) @(posedge clk);
    chk_rng(lit, 32'h3e6, 32'h4b4);
    repeat (800) @(posedge clk);
    chk({31'h0, ta}, 32'h0);
    bus(1'b1, `OLIPT_REG_DLY_RAW, 32'h0);
    bus(1'b1, `OLIPT_REG_DUR_RAW, 32'h1);
    trig;
    wt(1'b1);
    chk_rng(n, 32'h0, 32'h4);
    wt(1'b0);
    bus(1'b1, `OLIPT_REG_DLY_BASE, 32'h32);
    for (i = 0; i < 3; i = i + 1)
    begin
      bus(1'b1, `OLIPT_REG_DLY_ABS, (i == 0) ? 32'h78 : (i == 1) ? 32'h7d : 32'h18);
      rdc(`OLIPT_REG_DLY_RAW, (i == 0) ? 32'h2 : (i == 1) ? 32'h3 : 32'h0);
      rdc(`OLIPT_REG_DLY_ABS, (i == 0) ? 32'h64 : (i == 1) ? 32'h96 : 32'h0);
    end
    bus(1'b1, `OLIPT_REG_DUR_ABS, 32'h7);
    rdc(`OLIPT_REG_DUR_RAW, 32'h4);
    rdc(`OLIPT_REG_DUR_ABS, 32'h8);
    stop_test;
  end
endmodule // test_output_line_invert_and_pulse_timer
